/* rtl/lmra_byte_mem.sv */
// Purpose: Two-port byte memory for dot duty, sink scaling and fault results
// Assumes: Single clock; read data registered on both ports
// Notes:   Port a wins when both ports write one address in the same cycle
`timescale 1ns/10ps
`default_nettype none
module lmra_byte_mem #(
  parameter int DW    = 8,
  parameter int AW    = 8,
  parameter int DEPTH = 256
) (
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          clear,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [DW-1:0] a_wdata,
  output logic      [DW-1:0] a_rdata,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [DW-1:0] b_wdata,
  output logic      [DW-1:0] b_rdata
);
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("lmra_byte_mem: DEPTH exceeds address range");
  end

  logic [DW-1:0] mem_r [DEPTH];

  // Whole-array clear keeps the full reset a single cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (clear) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      if (b_we && !(a_we && a_addr == b_addr)) begin
        mem_r[b_addr] <= b_wdata;
      end
      if (a_we) begin
        mem_r[a_addr] <= a_wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= mem_r[a_addr];
      b_rdata <= mem_r[b_addr];
    end
  end
endmodule // lmra_byte_mem
`default_nettype wire

/* rtl/lmra_fault_trig.sv */
// Purpose: One-shot open and short test triggers from the detect enable field
// Assumes: Field comes from a register on the same clock
// Notes:   A new trigger needs the field to pass through zero first
`timescale 1ns/10ps
`default_nettype none
module lmra_fault_trig (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [1:0] fault_detect_enable,
  output logic            open_test_start,
  output logic            short_test_start
);
  logic armed_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      armed_r          <= 1'b1;
      open_test_start  <= 1'b0;
      short_test_start <= 1'b0;
    end else begin
      open_test_start  <= armed_r && fault_detect_enable[0];
      short_test_start <= armed_r && (fault_detect_enable == 2'h2);
      if (fault_detect_enable == 2'h0) begin
        armed_r <= 1'b1;
      end else begin
        armed_r <= 1'b0;
      end
    end
  end
endmodule // lmra_fault_trig
`default_nettype wire

/* rtl/lmra_pkg.sv */
// Purpose: Shared constants for the LED matrix register access block
// Assumes: 8-bit register space reached over a two-wire serial target port
// Notes:   Offsets, field positions and reset values live here only
package lmra_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          MEM_DEPTH     = 256;
  // Register map
  localparam logic [7:0]  DOT_FIRST     = 8'h01;
  localparam logic [7:0]  DOT_LAST      = 8'h8F;
  localparam logic [7:0]  SCALE_FIRST   = 8'h90;
  localparam logic [7:0]  SCALE_LAST    = 8'h9F;
  localparam logic [7:0]  CFG_ADDR      = 8'hA0;
  localparam logic [7:0]  GAIN_ADDR     = 8'hA1;
  localparam logic [7:0]  PULL_ADDR     = 8'hB0;
  localparam logic [7:0]  SPREAD_ADDR   = 8'hB1;
  localparam logic [7:0]  RATE_ADDR     = 8'hB2;
  localparam logic [7:0]  FAULT_FIRST   = 8'hB3;
  localparam logic [7:0]  FAULT_LAST    = 8'hC4;
  localparam logic [7:0]  RESET_ADDR    = 8'hCF;
  localparam logic [4:0]  FAULT_COUNT   = 5'h12;
  // Reset values, full reset key and gain ceiling
  localparam logic [7:0]  CFG_RST       = 8'h10;
  localparam logic [7:0]  GAIN_RST      = 8'h00;
  localparam logic [7:0]  PULL_RST      = 8'h33;
  localparam logic [7:0]  SPREAD_RST    = 8'h00;
  localparam logic [7:0]  RATE_RST      = 8'h01;
  localparam logic [7:0]  FULL_RESET_KEY = 8'hAE;
  localparam logic [7:0]  GAIN_MAX      = 8'h40;
  // Configuration fields
  localparam int          CFG_ROWS_MSB  = 7;
  localparam int          CFG_ROWS_LSB  = 4;
  localparam int          CFG_THR_BIT   = 3;
  localparam int          CFG_FDE_MSB   = 2;
  localparam int          CFG_FDE_LSB   = 1;
  localparam int          CFG_SSD_BIT   = 0;
  localparam int          RATE_MSB      = 2;
  // Target address: fixed upper five bits, two strap bits below
  localparam logic [4:0]  DEV_ADDR_HI   = 5'h0D;
  // Serial byte framing
  localparam logic [3:0]  BITS_DATA     = 4'h8;
  localparam logic [3:0]  BITS_ACK      = 4'h9;

  typedef enum logic [2:0] {
    LMRA_IDLE  = 3'h0,
    LMRA_DEV   = 3'h1,
    LMRA_REG   = 3'h3,
    LMRA_WDATA = 3'h2,
    LMRA_RDATA = 3'h6
  } lmra_state_t;
endpackage

/* rtl/lmra_top.sv */
// What this block does
// - Pointer advances by one per data byte, acked or not
// - Increment continues for the whole write
// - Repeated start, read address, selected data returned
// - Reset command register reads as zero
// - Duty byte per dot, zero at reset
// - Rate register selects modulation clock, default one
// - Drive follows duty byte times peak current
// - Scaling byte per column sink
// - Peak code is gain times scaling
// - Global gain register, resets to zero
// - Configuration fields: rows, threshold, detect, shutdown
// - Row count field defaults to one
// - Pull resistor register resets to 33h
// - Spread spectrum register resets to zero
// - Fault result bytes, zero at reset
// - Reset command restores all defaults
// - Only key AEh triggers full reset
// - Shutdown bit low means software shutdown
// - Gain above 40h treated as 40h
// - Each test fires once, rearm via zero
//
// Purpose: Register file and serial target access of a matrix LED driver
// Assumes: 200 MHz clock, far faster than the serial clock; pins synchronised
// Notes:   Analog sinks and scan timing sit outside and use the scan port
`timescale 1ns/10ps
`default_nettype none
module lmra_top
  import lmra_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [1:0]          addr_strap,
  input  wire logic                shutdown_pin_n,
  input  wire logic [lmra_pkg::ADDR_W-1:0] scan_addr,
  output logic [lmra_pkg::DATA_W-1:0]      scan_data,
  output logic [13:0]              sink_peak_code,
  input  wire logic                result_we,
  input  wire logic [4:0]          result_index,
  input  wire logic [7:0]          result_data,
  output logic [3:0]               row_count_select,
  output logic                     input_threshold_select,
  output logic                     soft_shutdown_n,
  output logic                     hw_shutdown,
  output logic [7:0]               global_current_gain,
  output logic [7:0]               pull_resistor_select,
  output logic [7:0]               spread_spectrum_control,
  output logic [2:0]               modulation_rate_select,
  output logic                     open_test_start,
  output logic                     short_test_start
);
  import lmra_pkg::*;

  if (SYNC_STAGES != 2) begin : g_chk
    $error("lmra_top: only a two-stage synchroniser is supported");
  end

  function automatic logic in_mem(input logic [7:0] a);
    in_mem = (a >= DOT_FIRST && a <= SCALE_LAST) || (a >= FAULT_FIRST && a <= FAULT_LAST);
  endfunction

  // Pin synchronisers; stage one feeds only stage two
  logic       scl_q1_r, sda_q1_r, sdb_q1_r;
  logic [1:0] strap_q1_r, strap_q2_r;
  logic       scl_q2_r, sda_q2_r, sdb_q2_r;
  logic       scl_q3_r, sda_q3_r, sdb_q3_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_q1_r   <= 1'b1;
      sda_q1_r   <= 1'b1;
      sdb_q1_r   <= 1'b0;
      strap_q1_r <= 2'h0;
      strap_q2_r <= 2'h0;
      scl_q2_r   <= 1'b1;
      sda_q2_r   <= 1'b1;
      sdb_q2_r   <= 1'b0;
      scl_q3_r   <= 1'b1;
      sda_q3_r   <= 1'b1;
      sdb_q3_r   <= 1'b0;
    end else begin
      scl_q1_r   <= scl_in;
      sda_q1_r   <= sda_in;
      sdb_q1_r   <= shutdown_pin_n;
      strap_q1_r <= addr_strap;
      strap_q2_r <= strap_q1_r;
      scl_q2_r   <= scl_q1_r;
      sda_q2_r   <= sda_q1_r;
      sdb_q2_r   <= sdb_q1_r;
      scl_q3_r   <= scl_q2_r;
      sda_q3_r   <= sda_q2_r;
      sdb_q3_r   <= sdb_q2_r;
    end
  end

  wire scl_rise   = scl_q2_r && !scl_q3_r;
  wire scl_fall   = !scl_q2_r && scl_q3_r;
  wire bus_start  = scl_q2_r && scl_q3_r && sda_q3_r && !sda_q2_r;
  wire bus_stop   = scl_q2_r && scl_q3_r && !sda_q3_r && sda_q2_r;
  // Shutdown pin rising edge restarts the serial interface
  wire sdb_rise   = sdb_q2_r && !sdb_q3_r;

  lmra_state_t state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        host_ack_r;
  logic        oe_r;
  logic [7:0]  cfg_r, gain_r, pull_r, spread_r, rate_r;

  wire [6:0] dev_addr    = {DEV_ADDR_HI, strap_q2_r};
  wire       byte_in     = scl_fall && (bit_cnt_r == BITS_DATA);
  wire       byte_done   = scl_fall && (bit_cnt_r == BITS_ACK);
  wire       dev_match   = (shift_r[7:1] == dev_addr);
  wire       wr_ev       = byte_in && (state_r == LMRA_WDATA);
  wire       full_reset  = wr_ev && (ptr_r == RESET_ADDR) && (shift_r == FULL_RESET_KEY);
  wire       tx_bit_slot = scl_fall && (state_r == LMRA_RDATA) && (bit_cnt_r != 4'h0)
                           && (bit_cnt_r < BITS_DATA);
  wire [2:0] tx_bit_idx  = 3'h7 - bit_cnt_r[2:0];

  // Register read selection
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;
  always_comb begin
    // Reset command and holes read zero
    rd_byte = 8'h00;
    if (in_mem(ptr_r)) begin
      rd_byte = mem_rdata;
    end else begin
      case (ptr_r)
        CFG_ADDR:    rd_byte = cfg_r;
        GAIN_ADDR:   rd_byte = gain_r;
        PULL_ADDR:   rd_byte = pull_r;
        SPREAD_ADDR: rd_byte = spread_r;
        RATE_ADDR:   rd_byte = rate_r;
        default:     rd_byte = 8'h00;
      endcase
    end
  end

  // Serial target sequencing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= LMRA_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= 8'h00;
      rw_r       <= 1'b0;
      host_ack_r <= 1'b0;
      oe_r       <= 1'b0;
    end else if (sdb_rise || bus_stop) begin
      state_r   <= LMRA_IDLE;
      bit_cnt_r <= 4'h0;
      oe_r      <= 1'b0;
    end else if (bus_start) begin
      state_r   <= LMRA_DEV;
      bit_cnt_r <= 4'h0;
      oe_r      <= 1'b0;
    end else if (state_r != LMRA_IDLE) begin
      if (scl_rise) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r < BITS_DATA) begin
          shift_r <= {shift_r[6:0], sda_q2_r};
        end
        if (bit_cnt_r == BITS_DATA && state_r == LMRA_RDATA) begin
          host_ack_r <= !sda_q2_r;
          ptr_r      <= ptr_r + 8'h01;
        end
      end
      if (byte_in) begin
        case (state_r)
          LMRA_DEV: begin
            rw_r <= shift_r[0];
            oe_r <= dev_match;
            if (!dev_match) begin
              state_r <= LMRA_IDLE;
            end
          end
          LMRA_REG: begin
            ptr_r <= shift_r;
            oe_r  <= 1'b1;
          end
          LMRA_WDATA: begin
            ptr_r <= ptr_r + 8'h01;
            oe_r  <= 1'b1;
          end
          default: oe_r <= 1'b0;
        endcase
      end else if (byte_done) begin
        bit_cnt_r <= 4'h0;
        oe_r      <= 1'b0;
        case (state_r)
          LMRA_DEV: begin
            if (rw_r) begin
              state_r <= LMRA_RDATA;
              tx_r    <= rd_byte;
              oe_r    <= !rd_byte[7];
            end else begin
              state_r <= LMRA_REG;
            end
          end
          LMRA_REG:   state_r <= LMRA_WDATA;
          LMRA_WDATA: state_r <= LMRA_WDATA;
          LMRA_RDATA: begin
            if (host_ack_r) begin
              tx_r <= rd_byte;
              oe_r <= !rd_byte[7];
            end else begin
              state_r <= LMRA_IDLE;
            end
          end
          default: state_r <= LMRA_IDLE;
        endcase
      end else if (tx_bit_slot) begin
        oe_r <= !tx_r[tx_bit_idx];
      end else if (scl_fall && state_r != LMRA_RDATA) begin
        oe_r <= 1'b0;
      end
    end
  end

  // Control registers; writes land in any power state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r    <= CFG_RST;
      gain_r   <= GAIN_RST;
      pull_r   <= PULL_RST;
      spread_r <= SPREAD_RST;
      rate_r   <= RATE_RST;
    end else if (full_reset) begin
      cfg_r    <= CFG_RST;
      gain_r   <= GAIN_RST;
      pull_r   <= PULL_RST;
      spread_r <= SPREAD_RST;
      rate_r   <= RATE_RST;
    end else if (wr_ev) begin
      case (ptr_r)
        CFG_ADDR:    cfg_r    <= shift_r;
        GAIN_ADDR:   gain_r   <= shift_r;
        PULL_ADDR:   pull_r   <= shift_r;
        SPREAD_ADDR: spread_r <= shift_r;
        RATE_ADDR:   rate_r   <= shift_r;
        default:     cfg_r    <= cfg_r;
      endcase
    end
  end

  // Byte storage for dots, sinks and results
  wire       mem_we       = wr_ev && in_mem(ptr_r);
  wire       res_ok       = result_we && (result_index < FAULT_COUNT);
  wire [7:0] res_addr     = FAULT_FIRST + {3'h0, result_index};
  wire [7:0] port_b_addr  = res_ok ? res_addr : scan_addr;
  logic [7:0] scan_rdata;

  lmra_byte_mem #(
    .DW    (DATA_W),
    .AW    (ADDR_W),
    .DEPTH (MEM_DEPTH)
  ) u_mem (
    .clock   (clock),
    .rst_b   (rst_b),
    .clear   (full_reset),
    .a_we    (mem_we),
    .a_addr  (ptr_r),
    .a_wdata (shift_r),
    .a_rdata (mem_rdata),
    .b_we    (res_ok),
    .b_addr  (port_b_addr),
    .b_wdata (result_data),
    .b_rdata (scan_rdata)
  );

  // One-shot tests from the detect field
  lmra_fault_trig u_trig (
    .clock               (clock),
    .rst_b               (rst_b),
    .fault_detect_enable (cfg_r[CFG_FDE_MSB:CFG_FDE_LSB]),
    .open_test_start     (open_test_start),
    .short_test_start    (short_test_start)
  );

  // Clamp applied to the used value only
  wire [7:0]  gain_eff  = (gain_r > GAIN_MAX) ? GAIN_MAX : gain_r;
  // Zero in either factor gives zero
  wire [15:0] peak_prod = gain_eff * scan_rdata;

  // Output staging; product and scan data leave on the same edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_out                 <= 1'b0;
      sda_oe                  <= 1'b0;
      scan_data               <= 8'h00;
      sink_peak_code          <= 14'h0000;
      row_count_select        <= CFG_RST[CFG_ROWS_MSB:CFG_ROWS_LSB];
      input_threshold_select  <= 1'b0;
      soft_shutdown_n         <= 1'b0;
      hw_shutdown             <= 1'b1;
      global_current_gain     <= GAIN_RST;
      pull_resistor_select    <= PULL_RST;
      spread_spectrum_control <= SPREAD_RST;
      modulation_rate_select  <= RATE_RST[RATE_MSB:0];
    end else begin
      sda_out                 <= 1'b0;
      sda_oe                  <= oe_r;
      // Duty byte handed to the scan engine
      scan_data               <= scan_rdata;
      sink_peak_code          <= peak_prod[13:0];
      row_count_select        <= cfg_r[CFG_ROWS_MSB:CFG_ROWS_LSB];
      input_threshold_select  <= cfg_r[CFG_THR_BIT];
      soft_shutdown_n         <= cfg_r[CFG_SSD_BIT];
      hw_shutdown             <= !sdb_q2_r;
      global_current_gain     <= gain_eff;
      pull_resistor_select    <= pull_r;
      spread_spectrum_control <= spread_r;
      modulation_rate_select  <= rate_r[RATE_MSB:0];
    end
  end
endmodule // lmra_top
`default_nettype wire

/* tb/lmra_checker_properties.sv */
// Purpose: Concurrent checks on the register access top ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the design top from the bench top file
`timescale 1ns/10ps
`default_nettype none
module lmra_checker_properties (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [7:0]  scan_data,
  input wire logic [13:0] sink_peak_code,
  input wire logic [7:0]  global_current_gain,
  input wire logic        open_test_start,
  input wire logic        short_test_start
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_sda_pull_only: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data pin driven high");
  // Moving SDA while SCL is high would look like a START or STOP to the host
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive changed while serial clock high");
  a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*3])
    else $error("acknowledge dropped too early");
  a_open_single: assert property (open_test_start |=> !open_test_start)
    else $error("open test start longer than one cycle");
  a_short_single: assert property (short_test_start |=> !short_test_start)
    else $error("short test start longer than one cycle");
  a_tests_exclusive: assert property (!(open_test_start && short_test_start))
    else $error("both tests started together");
  a_gain_ceiling: assert property (global_current_gain <= 8'h40)
    else $error("gain above ceiling");
  // Product, gain and scan byte are staged by the same flop edge
  a_peak_product: assert property (
    sink_peak_code == {6'h00, global_current_gain} * {6'h00, scan_data})
    else $error("peak code is not gain times scaling");
endmodule // lmra_checker_properties
`default_nettype wire

/* tb/lmra_host_model.sv */
// Purpose: Serial bus controller model driving the target port
// Assumes: Eight clocks per serial clock phase
// Notes:   Open-drain data wire with pull-up resolved here
`timescale 1ns/10ps
`default_nettype none
module lmra_host_model (
  input  wire logic clock,
  input  wire logic sda_oe,
  output var logic  scl,
  output wire logic sda
);
  logic host_sda_r;
  // Pull-up wins when neither party pulls low
  assign sda = host_sda_r & ~sda_oe;
  initial begin
    scl = 1'b1;
    host_sda_r = 1'b1;
  end
  task automatic drive(input logic c, input logic d);
    scl <= c;
    host_sda_r <= d;
    repeat (8) @(posedge clock);
  endtask
  task automatic start();
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
  endtask
  task automatic stop();
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask
  // bytes go out most significant bit first
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drive(1'b0, b[i]);
      drive(1'b1, b[i]);
    end
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    ack = ~sda;
  endtask
  // last byte of a read is answered with a not-acknowledge
  task automatic recv(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      b[i] = sda;
    end
    // Low acknowledges and asks for more; high on the last byte ends the read
    drive(1'b0, last);
    drive(1'b1, last);
  endtask
endmodule // lmra_host_model
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the register access block
// Assumes: Host model on the serial port, strap 10, pin out of shutdown
// Notes:   Expected values are literals; register offsets come from the register map constants, except the literal addresses 8Eh, 8Fh, 90h, C8h and B5h
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import lmra_pkg::*;
  localparam logic [6:0] DEV = {DEV_ADDR_HI, 2'b10};
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        scl;
  wire  logic  sda;
  logic        sda_out, sda_oe, sw_n, thr, hw_sd, o_st, s_st;
  logic [7:0]  scan_addr = 8'h00;
  logic [7:0]  scan_data, gain, pull, spread;
  logic [13:0] peak;
  logic        result_we = 1'b0;
  logic [4:0]  result_index = 5'h00;
  logic [7:0]  result_data = 8'h00;
  logic [3:0]  rows;
  logic [2:0]  rate;
  int          num_errors, samples_checked, cycles, open_cnt, short_cnt;

  always #2.5 clock = ~clock;

  lmra_host_model host_i (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  lmra_top lmra_top_i (
    .clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap(2'b10), .shutdown_pin_n(1'b1), .scan_addr(scan_addr),
    .scan_data(scan_data), .sink_peak_code(peak), .result_we(result_we),
    .result_index(result_index), .result_data(result_data), .row_count_select(rows),
    .input_threshold_select(thr), .soft_shutdown_n(sw_n), .hw_shutdown(hw_sd),
    .global_current_gain(gain), .pull_resistor_select(pull),
    .spread_spectrum_control(spread), .modulation_rate_select(rate),
    .open_test_start(o_st), .short_test_start(s_st));

  always @(posedge clock) begin
    cycles++;
    if (o_st === 1'b1) open_cnt++;
    if (s_st === 1'b1) short_cnt++;
    // Whole plan needs about 25000 cycles
    if (cycles == 60000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic snd(input logic [7:0] b);
    logic ack;
    host_i.send(b, ack);
    `CHECK(ack, 1'b1)
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d, input int n);
    host_i.start();
    snd({DEV, 1'b0});
    snd(r);
    for (int k = 0; k < n; k++) snd(8'(d + 8'(k)));
    host_i.stop();
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] e, input int n, input logic [7:0] s);
    logic [7:0] b;
    host_i.start();
    snd({DEV, 1'b0});
    snd(r);
    host_i.start();
    snd({DEV, 1'b1});
    for (int k = 0; k < n; k++) begin
      host_i.recv(k == n - 1, b);
      `CHECK(b, 8'(e + s * 8'(k)))
    end
    host_i.stop();
  endtask

  initial begin
    logic ack;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
    `CHECK(rows, 4'h1)
    `CHECK(pull, 8'h33)
    `CHECK(rate, 3'h1)
    rd(CFG_ADDR, 8'h10, 1, 8'h00);
    rd(GAIN_ADDR, 8'h00, 1, 8'h00);
    rd(PULL_ADDR, 8'h33, 1, 8'h00);
    rd(SPREAD_ADDR, 8'h00, 2, 8'h01);
    rd(FAULT_FIRST, 8'h00, 18, 8'h00);
    rd(RESET_ADDR, 8'h00, 1, 8'h00);
    rd(DOT_FIRST, 8'h00, 1, 8'h00);
    wr(8'h8E, 8'h20, 5);
    rd(8'h8E, 8'h20, 5, 8'h01);
    wr(GAIN_ADDR, 8'h7F, 1);
    rd(GAIN_ADDR, 8'h7F, 1, 8'h00);
    `CHECK(gain, 8'h40)
    scan_addr <= 8'h90;
    repeat (6) @(posedge clock);
    `CHECK(scan_data, 8'h22)
    `CHECK(peak, 14'h0880)
    scan_addr <= 8'h8F;
    repeat (6) @(posedge clock);
    `CHECK(scan_data, 8'h21)
    `CHECK(peak, 14'h0840)
    wr(CFG_ADDR, 8'h3B, 1);
    `CHECK({rows, thr, sw_n, hw_sd}, 7'h1E)
    `CHECK(open_cnt, 1)
    wr(CFG_ADDR, 8'h3D, 1);
    `CHECK(short_cnt, 0)
    wr(CFG_ADDR, 8'h39, 1);
    wr(CFG_ADDR, 8'h3D, 1);
    wr(CFG_ADDR, 8'h39, 1);
    wr(CFG_ADDR, 8'h3F, 1);
    `CHECK(short_cnt, 1)
    `CHECK(open_cnt, 2)
    for (int c = 0; c < 8; c++) begin
      wr(RATE_ADDR, 8'(c), 1);
      `CHECK(rate, 3'(c))
    end
    wr(SPREAD_ADDR, 8'h1F, 1);
    `CHECK(spread, 8'h1F)
    wr(8'hC8, 8'h55, 1);
    rd(8'hC8, 8'h00, 1, 8'h00);
    result_index <= 5'h02;
    result_data <= 8'hA5;
    result_we <= 1'b1;
    @(posedge clock);
    result_we <= 1'b0;
    rd(8'hB5, 8'hA5, 1, 8'h00);
    host_i.start();
    host_i.send({DEV_ADDR_HI, 2'b01, 1'b0}, ack);
    host_i.stop();
    `CHECK(ack, 1'b0)
    wr(RESET_ADDR, 8'h12, 1);
    rd(RATE_ADDR, 8'h07, 1, 8'h00);
    wr(RESET_ADDR, FULL_RESET_KEY, 1);
    rd(RATE_ADDR, 8'h01, 1, 8'h00);
    rd(8'h8E, 8'h00, 5, 8'h00);
    `CHECK(scan_data, 8'h00)
    `CHECK({rows, sw_n, gain}, 13'h0200)
    summarize();
  end
endmodule // tb_top

bind lmra_top lmra_checker_properties chk_i (
  .clock(clock), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .scan_data(scan_data), .sink_peak_code(sink_peak_code),
  .global_current_gain(global_current_gain), .open_test_start(open_test_start),
  .short_test_start(short_test_start));
`default_nettype wire
